// ==== sac_consts.vh ====
// Purpose: shared constants of the converter control block
// Assumes: included by every design file of the block
// Notes: addresses are data-space byte addresses
`ifndef SAC_CONSTS_VH
`define SAC_CONSTS_VH

// data-space addresses
`define SAC_ADDR_RESULT 8'hd0
`define SAC_ADDR_CTRL 8'hd1

// control register layout and reset value
`define SAC_CTRL_RESET 8'h40
`define SAC_BIT_IRQ_EN 7
`define SAC_BIT_DONE 6
`define SAC_BIT_START 5
`define SAC_BIT_PWR 4
`define SAC_RESULT_RESET 8'h00
`define SAC_ZERO_BYTE 8'h00

// conversion clock divider: divide by twelve
`define SAC_DIV_W 4
`define SAC_DIV_LAST 4'hb
`define SAC_DIV_ZERO 4'h0
`define SAC_DIV_ONE 4'h1

// successive approximation sequence
`define SAC_STEP_W 3
`define SAC_STEP_FIRST 3'h7
`define SAC_STEP_LAST 3'h0
`define SAC_STEP_ONE 3'h1
`define SAC_TRIAL_FIRST 8'h80

// interrupt vector of the end-of-conversion request
`define SAC_IRQ_VECTOR 3'h4

// control sequencer states
`define SAC_ST_IDLE 2'b00
`define SAC_ST_ARMED 2'b01
`define SAC_ST_RUN 2'b10

`endif

// ==== sac_clk_div.v ====
// Purpose: conversion clock tick, system clock divided by twelve
// Assumes: one clock, synchronous active-low reset, clock enable
// Notes: restart realigns the tick so every conversion has equal timing
`timescale 1ns/1ns
`include "sac_consts.vh"

module sac_clk_div (
    input wire sys_clk,
    input wire rst_n,
    input wire clk_en,
    input wire run,
    input wire restart,
    output reg tick_q
);

reg [`SAC_DIV_W-1:0] cnt_q;

always @(posedge sys_clk) begin
    if (!rst_n) begin
        cnt_q <= `SAC_DIV_ZERO;
        tick_q <= 1'b0;
    end else if (clk_en) begin
        if (restart || !run) begin
            cnt_q <= `SAC_DIV_ZERO;
            tick_q <= 1'b0;
        end else if (cnt_q == `SAC_DIV_LAST) begin
            cnt_q <= `SAC_DIV_ZERO;
            tick_q <= 1'b1;
        end else begin
            cnt_q <= cnt_q + `SAC_DIV_ONE;
            tick_q <= 1'b0;
        end
    end
end

endmodule

// ==== sac_sar_seq.v ====
// Purpose: eight-step successive approximation sequencer
// Assumes: cmp_hi is synchronised, high when input is at or above the trial level
// Notes: finish and final_code are combinational so the parent can latch them
`timescale 1ns/1ns
`include "sac_consts.vh"

module sac_sar_seq (
    input wire sys_clk,
    input wire rst_n,
    input wire clk_en,
    input wire go,
    input wire abort,
    input wire tick,
    input wire cmp_hi,
    output reg busy_q,
    output reg [7:0] trial_q,
    output wire finish,
    output wire [7:0] final_code
);

reg [`SAC_STEP_W-1:0] step_q;
wire [7:0] bit_mask;
wire [7:0] decided;

assign bit_mask = `SAC_TRIAL_FIRST >> step_q_inv(step_q);
// keep the trial bit only when the input sits at or above the trial level
assign decided = cmp_hi ? trial_q : (trial_q & ~bit_mask);
assign finish = busy_q && tick && (step_q == `SAC_STEP_LAST) && !go && !abort;
assign final_code = decided;

function [2:0] step_q_inv;
    input [2:0] s;
    begin
        step_q_inv = `SAC_STEP_FIRST - s;
    end
endfunction

always @(posedge sys_clk) begin
    if (!rst_n) begin
        busy_q <= 1'b0;
        step_q <= `SAC_STEP_FIRST;
        trial_q <= `SAC_ZERO_BYTE;
    end else if (clk_en) begin
        if (go) begin
            busy_q <= 1'b1;
            step_q <= `SAC_STEP_FIRST;
            trial_q <= `SAC_TRIAL_FIRST;
        end else if (abort) begin
            busy_q <= 1'b0;
            step_q <= `SAC_STEP_FIRST;
            trial_q <= `SAC_ZERO_BYTE;
        end else if (busy_q && tick) begin
            if (step_q == `SAC_STEP_LAST) begin
                busy_q <= 1'b0;
                trial_q <= decided;
            end else begin
                step_q <= step_q - `SAC_STEP_ONE;
                trial_q <= decided | (bit_mask >> 1);
            end
        end
    end
end

endmodule

// ==== sac_adc_ctrl.v ====
// Purpose: control and status logic of an 8-bit successive approximation converter
// Assumes: core bus and wait status are on sys_clk; comparator output is not
// Notes: read data is registered and valid the cycle after the read strobe
// Function
// R1 - control bit 7 enables the end-of-conversion interrupt request
// R2 - control bit 6 is a completion flag set by hardware, writes ignored
// R3 - completion flag is the pending indication; result valid while it is one
// R4 - writing one to bit 5 starts conversion and clears the completion flag
// R5 - start during a running conversion abandons it and begins a new one
// R6 - start bit is write-only and always reads zero
// R7 - bit 4 powers the converter; zero selects idle power-down
// R8 - read-only result register at d0 holds the 8-bit conversion result
// R9 - synchronised start holds the conversion until the core is in wait mode
// R10 - software must issue wait right after a synchronised start write
// R11 - end-of-conversion interrupt wakes the core from wait mode
// R12 - conversion clock is the oscillator clock divided by twelve
// R13 - reset halts conversion and sets control to 40h, interrupt masked
// R14 - end-of-conversion request goes out on interrupt vector four
// R15 - result register updates in the same cycle the completion flag sets
`timescale 1ns/1ns
`include "sac_consts.vh"

module sac_adc_ctrl (
    input wire sys_clk,
    input wire rst_n,
    input wire clk_en,
    input wire [7:0] bus_addr,
    input wire [7:0] bus_wdata,
    input wire bus_wr,
    input wire bus_rd,
    output reg [7:0] bus_rdata_q,
    input wire sync_start_opt,
    input wire core_in_wait,
    input wire cmp_in,
    output reg [7:0] dac_code_q,
    output reg adc_power_q,
    output reg conv_busy_q,
    output reg irq_req_q,
    output reg [2:0] irq_vector_q,
    output reg wake_req_q
);

localparam ST_IDLE = `SAC_ST_IDLE;
localparam ST_ARMED = `SAC_ST_ARMED;
localparam ST_RUN = `SAC_ST_RUN;
localparam [7:0] CTRL_RESET = `SAC_CTRL_RESET;

// control register fields
reg irq_en_q;
reg done_q;
reg pwr_q;
reg [7:0] result_q;
reg [1:0] state_q;
reg [1:0] state_d;

// comparator synchroniser
reg cmp_meta_q;
reg cmp_sync_q;

// bus decode
wire wr_ctrl;
wire rd_ctrl;
wire rd_result;
wire start_req;
wire pwr_next;

// sequencer handshake
reg sar_go;
reg sar_abort;
wire div_tick;
wire sar_busy;
wire [7:0] sar_trial;
wire sar_finish;
wire [7:0] sar_code;
wire [7:0] ctrl_view;

assign wr_ctrl = bus_wr && (bus_addr == `SAC_ADDR_CTRL);
assign rd_ctrl = bus_rd && (bus_addr == `SAC_ADDR_CTRL);
assign rd_result = bus_rd && (bus_addr == `SAC_ADDR_RESULT);
assign start_req = wr_ctrl && bus_wdata[`SAC_BIT_START]; // [R4]
assign pwr_next = wr_ctrl ? bus_wdata[`SAC_BIT_PWR] : pwr_q;

// start bit is never stored, so it reads as zero; low nibble unused
assign ctrl_view = {irq_en_q, done_q, 1'b0, pwr_q, 4'h0}; // [R6]

// comparator arrives from the analog side, two flops before use
always @(posedge sys_clk) begin
    if (!rst_n) begin
        cmp_meta_q <= 1'b0;
        cmp_sync_q <= 1'b0;
    end else if (clk_en) begin
        cmp_meta_q <= cmp_in;
        cmp_sync_q <= cmp_meta_q;
    end
end

// conversion start sequencer
always @* begin
    state_d = state_q;
    sar_go = 1'b0;
    sar_abort = 1'b0;
    case (state_q)
        ST_IDLE: begin
            if (start_req && pwr_next) begin
                if (sync_start_opt && !core_in_wait) begin
                    state_d = ST_ARMED; // [R9]
                end else begin
                    state_d = ST_RUN; // [R4]
                    sar_go = 1'b1;
                end
            end
        end
        ST_ARMED: begin
            if (!pwr_next) begin
                state_d = ST_IDLE; // [R7]
            end else if (core_in_wait || (start_req && !sync_start_opt)) begin
                // release the held start once the core has really stopped
                state_d = ST_RUN; // [R9] [R10]
                sar_go = 1'b1;
            end
        end
        ST_RUN: begin
            if (!pwr_next) begin
                state_d = ST_IDLE; // [R7]
                sar_abort = 1'b1;
            end else if (start_req) begin
                if (sync_start_opt && !core_in_wait) begin
                    state_d = ST_ARMED; // [R5] [R9]
                    sar_abort = 1'b1;
                end else begin
                    sar_go = 1'b1; // [R5]
                end
            end else if (sar_finish) begin
                state_d = ST_IDLE;
            end
        end
        default: begin
            state_d = ST_IDLE;
            sar_abort = 1'b1;
        end
    endcase
end

always @(posedge sys_clk) begin
    if (!rst_n) begin
        state_q <= ST_IDLE; // [R13]
    end else if (clk_en) begin
        state_q <= state_d;
    end
end

// control register
always @(posedge sys_clk) begin
    if (!rst_n) begin
        irq_en_q <= CTRL_RESET[`SAC_BIT_IRQ_EN]; // [R13]
        done_q <= CTRL_RESET[`SAC_BIT_DONE]; // [R13]
        pwr_q <= CTRL_RESET[`SAC_BIT_PWR]; // [R13]
    end else if (clk_en) begin
        if (wr_ctrl) begin
            irq_en_q <= bus_wdata[`SAC_BIT_IRQ_EN]; // [R1]
            pwr_q <= bus_wdata[`SAC_BIT_PWR]; // [R7]
        end
        // a start write in the finishing cycle suppresses sar_finish, so its clear wins over the hardware set
        if (sar_finish) begin
            done_q <= 1'b1; // [R2] [R15]
        end else if (start_req) begin
            done_q <= 1'b0; // [R4]
        end
    end
end

// result register, loaded on the edge that sets the completion flag
always @(posedge sys_clk) begin
    if (!rst_n) begin
        result_q <= `SAC_RESULT_RESET;
    end else if (clk_en) begin
        if (sar_finish) begin
            result_q <= sar_code; // [R15] [R8]
        end
    end
end

// registered read data; unmapped addresses answer zero
always @(posedge sys_clk) begin
    if (!rst_n) begin
        bus_rdata_q <= `SAC_ZERO_BYTE;
    end else if (clk_en) begin
        if (rd_ctrl) begin
            bus_rdata_q <= ctrl_view; // [R2] [R6]
        end else if (rd_result) begin
            bus_rdata_q <= result_q; // [R8] [R3]
        end else if (bus_rd) begin
            bus_rdata_q <= `SAC_ZERO_BYTE;
        end
    end
end

// interrupt request, wake request and analog side controls
always @(posedge sys_clk) begin
    if (!rst_n) begin
        irq_req_q <= 1'b0; // [R13]
        irq_vector_q <= `SAC_IRQ_VECTOR;
        wake_req_q <= 1'b0;
        adc_power_q <= 1'b0;
        conv_busy_q <= 1'b0;
        dac_code_q <= `SAC_ZERO_BYTE;
    end else if (clk_en) begin
        // the completion flag is the pending bit, gated by the enable
        irq_req_q <= irq_en_q && done_q; // [R1] [R3] [R14]
        irq_vector_q <= `SAC_IRQ_VECTOR; // [R14]
        wake_req_q <= irq_en_q && done_q && core_in_wait; // [R11]
        adc_power_q <= pwr_q; // [R7]
        conv_busy_q <= sar_busy;
        dac_code_q <= sar_trial;
    end
end

sac_clk_div u_div (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .clk_en(clk_en),
    .run(sar_busy),
    .restart(sar_go),
    .tick_q(div_tick) // [R12]
);

sac_sar_seq u_sar (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .clk_en(clk_en),
    .go(sar_go),
    .abort(sar_abort),
    .tick(div_tick),
    .cmp_hi(cmp_sync_q),
    .busy_q(sar_busy),
    .trial_q(sar_trial),
    .finish(sar_finish),
    .final_code(sar_code)
);

endmodule

// ==== sac_cmp_model.sv ====
// Purpose: comparator stand-in at the analog side of the converter
// Assumes: ideal comparator, input level held steady by the bench
// Notes: high while the input level is at or above the trial code
`timescale 1ns/1ns
module sac_cmp_model (
    input wire [7:0] ain,
    input wire [7:0] dac_code,
    output wire cmp_out
);
    assign cmp_out = ain >= dac_code;
endmodule

// ==== sac_chk_sva.sv ====
// Purpose: port checker of the converter control block
// Assumes: one clock, bus strobes are one-cycle pulses
// Notes: bound to sac_adc_ctrl from the bench top file
`timescale 1ns/1ns
`include "sac_consts.vh"
module sac_chk (
    input wire sys_clk,
    input wire rst_n,
    input wire clk_en,
    input wire [7:0] bus_addr,
    input wire [7:0] bus_wdata,
    input wire bus_wr,
    input wire bus_rd,
    input wire [7:0] bus_rdata_q,
    input wire sync_start_opt,
    input wire core_in_wait,
    input wire [7:0] dac_code_q,
    input wire adc_power_q,
    input wire conv_busy_q,
    input wire irq_req_q,
    input wire [2:0] irq_vector_q,
    input wire wake_req_q
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    wire wr_c = clk_en && bus_wr && bus_addr == `SAC_ADDR_CTRL;
    wire go = wr_c && bus_wdata[5] && bus_wdata[4];
    property p_vec; irq_vector_q == `SAC_IRQ_VECTOR; endproperty
    a_vec: assert property (p_vec) else $error("irq vector wrong");
    property p_start; go && !sync_start_opt |-> ##2 conv_busy_q && !irq_req_q; endproperty
    a_start: assert property (p_start) else $error("start not taken");
    property p_sync; go && sync_start_opt && !core_in_wait |-> ##2 !conv_busy_q; endproperty
    a_sync: assert property (p_sync) else $error("sync start not held");
    property p_pdown; wr_c && !bus_wdata[4] |-> ##2 !conv_busy_q && !adc_power_q; endproperty
    a_pdown: assert property (p_pdown) else $error("power down ignored");
    property p_mask; wr_c && !bus_wdata[7] |-> ##2 !irq_req_q && !wake_req_q; endproperty
    a_mask: assert property (p_mask) else $error("irq not masked");
    property p_rd;
        clk_en && bus_rd && bus_addr == `SAC_ADDR_CTRL |=> bus_rdata_q[5] == 1'b0
            && bus_rdata_q[3:0] == 4'h0;
    endproperty
    a_rd: assert property (p_rd) else $error("start or unused bits read back");
    property p_step;
        disable iff (!rst_n || bus_wr) $changed(dac_code_q) && conv_busy_q |=>
            $stable(dac_code_q) [*8] ##1 $stable(dac_code_q) [*3];
    endproperty
    a_step: assert property (p_step) else $error("trial step too short");
    property p_wake; wake_req_q |-> irq_req_q && $past(core_in_wait); endproperty
    a_wake: assert property (p_wake) else $error("wake without pending irq");
    property p_rst;
        @(posedge sys_clk) disable iff (1'b0) !rst_n |=> !conv_busy_q && !adc_power_q
            && !irq_req_q;
    endproperty
    a_rst: assert property (p_rst) else $error("reset state wrong");
    c_go: cover property (go ##2 conv_busy_q);
    c_wake: cover property ($rose(wake_req_q));
    c_sync: cover property (go && sync_start_opt && !core_in_wait);
endmodule

// ==== tb_sar_adc_control_interface.sv ====
// Purpose: register-level bench of the converter control block
// Assumes: comparator model tracks a held input level
// Notes: core bus driven 1 ns after the rising edge
`timescale 1ns/1ns
`include "sac_consts.vh"
`define CHK(n, e, s) begin comparisons = comparisons + 1; if ((s) !== (e)) begin \
    num_errors = num_errors + 1; $display("CHECK FAILED %s exp %h got %h", n, e, s); end end
module tb_sar_adc_control_interface;
    reg sys_clk = 1'b0;
    reg rst_n = 1'b0;
    reg clk_en = 1'b1;
    reg [7:0] bus_addr = 8'h00;
    reg [7:0] bus_wdata = 8'h00;
    reg bus_wr = 1'b0;
    reg bus_rd = 1'b0;
    reg sync_start_opt = 1'b0;
    reg core_in_wait = 1'b0;
    reg [7:0] ain = 8'h00;
    reg [7:0] v;
    wire cmp;
    wire [7:0] rdata;
    wire [7:0] dac;
    wire [2:0] vec;
    wire pwr, busy, irq, wake;
    integer num_errors = 0;
    integer comparisons = 0;
    always #20 sys_clk = ~sys_clk;
    sac_adc_ctrl dut (.sys_clk(sys_clk), .rst_n(rst_n), .clk_en(clk_en), .bus_addr(bus_addr),
        .bus_wdata(bus_wdata), .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata_q(rdata),
        .sync_start_opt(sync_start_opt), .core_in_wait(core_in_wait), .cmp_in(cmp),
        .dac_code_q(dac), .adc_power_q(pwr), .conv_busy_q(busy), .irq_req_q(irq),
        .irq_vector_q(vec), .wake_req_q(wake));
    sac_cmp_model u_cmp (.ain(ain), .dac_code(dac), .cmp_out(cmp));
    task conclude; begin
        $display("counts: %0d comparisons, %0d mismatches", comparisons, num_errors);
        if (num_errors == 0 && comparisons > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    end endtask
    task cyc(input integer n); repeat (n) @(posedge sys_clk); endtask
    task wr(input [7:0] a, input [7:0] d); begin
        @(posedge sys_clk); #1 bus_addr = a; bus_wdata = d; bus_wr = 1'b1;
        @(posedge sys_clk); #1 bus_wr = 1'b0;
    end endtask
    task rd(input [7:0] a, output [7:0] d); begin
        @(posedge sys_clk); #1 bus_addr = a; bus_rd = 1'b1;
        @(posedge sys_clk); #1 bus_rd = 1'b0; d = rdata;
    end endtask
    task wait_done; integer k; begin
        v = 8'h00;
        for (k = 0; k < 80 && v[6] !== 1'b1; k = k + 1)
            rd(`SAC_ADDR_CTRL, v);
        if (v[6] !== 1'b1) begin
            num_errors = num_errors + 1;
            $display("CHECK FAILED done_wait exp 1 got %h", v[6]);
            conclude;
        end
    end endtask
    initial begin
        #4000000 num_errors = num_errors + 1;
        $display("CHECK FAILED run_time exp end got hang");
        conclude;
    end
    initial begin
        cyc(10); #1 rst_n = 1'b1;
        rd(`SAC_ADDR_CTRL, v); `CHK("ctrl_reset", 8'h40, v)
        rd(`SAC_ADDR_RESULT, v); `CHK("result_reset", 8'h00, v)
        rd(8'h55, v); `CHK("unmapped", 8'h00, v)
        `CHK("vector", 3'h4, vec)
        $display("test reset done");
        ain = 8'ha5; wr(`SAC_ADDR_CTRL, 8'hf0);
        rd(`SAC_ADDR_CTRL, v); `CHK("ctrl_started", 8'h90, v)
        `CHK("busy_on", 1'b1, busy)
        `CHK("dac_first", 8'h80, dac)
        `CHK("power_on", 1'b1, pwr)
        cyc(85); rd(`SAC_ADDR_CTRL, v); `CHK("ctrl_early", 8'h90, v)
        wait_done; `CHK("ctrl_done", 8'hd0, v)
        rd(`SAC_ADDR_RESULT, v); `CHK("result", 8'ha5, v)
        `CHK("irq_on", 1'b1, irq)
        `CHK("dac_final", 8'ha5, dac)
        wr(`SAC_ADDR_RESULT, 8'h3c); rd(`SAC_ADDR_RESULT, v); `CHK("result_ro", 8'ha5, v)
        wr(`SAC_ADDR_CTRL, 8'h10); cyc(2); #1 `CHK("irq_masked", 1'b0, irq)
        rd(`SAC_ADDR_CTRL, v); `CHK("flag_kept", 8'h50, v)
        clk_en = 1'b0; wr(`SAC_ADDR_CTRL, 8'h20); clk_en = 1'b1; // start write while frozen
        rd(`SAC_ADDR_CTRL, v); `CHK("frozen_write", 8'h50, v)
        $display("test convert done");
        ain = 8'h5a; wr(`SAC_ADDR_CTRL, 8'hb0); cyc(50);
        ain = 8'h3c; wr(`SAC_ADDR_CTRL, 8'hb0); cyc(60);
        rd(`SAC_ADDR_CTRL, v); `CHK("restart_busy", 8'h90, v)
        wait_done; rd(`SAC_ADDR_RESULT, v); `CHK("restart_result", 8'h3c, v)
        $display("test restart done");
        wr(`SAC_ADDR_CTRL, 8'hb0); cyc(20); wr(`SAC_ADDR_CTRL, 8'h80); cyc(120);
        rd(`SAC_ADDR_CTRL, v); `CHK("pdown_ctrl", 8'h80, v)
        `CHK("pdown_power", 1'b0, pwr)
        `CHK("pdown_busy", 1'b0, busy)
        $display("test power down done");
        sync_start_opt = 1'b1; wr(`SAC_ADDR_CTRL, 8'hb0); cyc(6);
        #1 core_in_wait = 1'b1; // core enters wait six cycles after the start write
        `CHK("sync_held", 1'b0, busy)
        wait_done; `CHK("wake", 1'b1, wake)
        $display("test sync start done");
        sync_start_opt = 1'b0; core_in_wait = 1'b0;
        wr(`SAC_ADDR_CTRL, 8'hb0); cyc(10); #1 rst_n = 1'b0;
        `CHK("busy_pre_reset", 1'b1, busy)
        cyc(2); #1 rst_n = 1'b1;
        `CHK("reset_busy", 1'b0, busy)
        `CHK("reset_dac", 8'h00, dac)
        rd(`SAC_ADDR_CTRL, v); `CHK("ctrl_rereset", 8'h40, v)
        $display("test mid-run reset done");
        conclude;
    end
endmodule
bind sac_adc_ctrl sac_chk u_chk (.sys_clk(sys_clk), .rst_n(rst_n), .clk_en(clk_en),
    .bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_wr(bus_wr), .bus_rd(bus_rd),
    .bus_rdata_q(bus_rdata_q), .sync_start_opt(sync_start_opt), .core_in_wait(core_in_wait),
    .dac_code_q(dac_code_q), .adc_power_q(adc_power_q), .conv_busy_q(conv_busy_q),
    .irq_req_q(irq_req_q), .irq_vector_q(irq_vector_q), .wake_req_q(wake_req_q));
